//--- shared/uart_lsr_pkg.sv
package uart_lsr_pkg;
    // Register select values on the parallel bus.
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IRQ_EN = 3'h1;
    localparam logic [2:0] REG_IDENT = 3'h2;
    localparam logic [2:0] REG_LSTAT = 3'h5;
    // Line status bit positions.
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_BI = 4;
    localparam int LS_TX_HOLDING_EMPTY = 5;
    localparam int LS_TX_ALL_EMPTY = 6;
    localparam int LS_EIRF = 7;
    // Interrupt enable bit positions and the FIFO control bits used here.
    localparam int IE_RDA = 0;
    localparam int IE_TX_HOLDING_EMPTY = 1;
    localparam int IE_RLS = 2;
    localparam int IE_MS = 3;
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_CLR = 1;
    localparam int FC_TX_CLR = 2;
    // Source codes for identification bits 3 to 1.
    localparam logic [2:0] ID_RLS = 3'h3;
    localparam logic [2:0] ID_RDA = 3'h2;
    localparam logic [2:0] ID_TMO = 3'h6;
    localparam logic [2:0] ID_TX_HOLDING_EMPTY = 3'h1;
    localparam logic [2:0] ID_MS = 3'h0;
    localparam logic [1:0] MODE_FIFO = 2'h3;
    localparam logic [1:0] MODE_CHAR = 2'h0;
    // Values after master reset.
    localparam logic [7:0] IDENT_RESET = 8'h01;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    // Bit timing in ticks of the sixteen-times baud clock.
    localparam int TICKS_PER_BIT = 16;
    localparam int HALF_BIT_TICKS = TICKS_PER_BIT / 2;
    localparam int CHAR_BITS = 10;
    localparam int CHAR_TICKS = CHAR_BITS * TICKS_PER_BIT;
    localparam int TX_EMPTY_DELAY_TICKS = CHAR_TICKS - TICKS_PER_BIT;
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_TICKS = TIMEOUT_CHARS * CHAR_TICKS;
    // One received character with its error status.
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } rx_word_t;
    // One parallel bus cycle from the CPU.
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bus_req_t;
endpackage : uart_lsr_pkg

//--- verilog/uart_line_status_irq_id.sv
`timescale 1ns/10ps
// Flip-flop FIFO with valid and ready on both sides.
module line_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [CW-1:0] cnt, next_cnt;
    logic push, pop;
    // Full and empty come straight from the occupancy count.
    assign in_ready_o = (cnt != CW'(DEPTH));
    assign out_valid_o = (cnt != '0);
    assign out_data_o = mem[rp];
    assign count_o = cnt;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Pointer and count update; a clear discards everything held.
    always_comb
    begin
        next_wp = push ? AW'((32'(wp) + 1) % DEPTH) : wp;
        next_rp = pop ? AW'((32'(rp) + 1) % DEPTH) : rp;
        next_cnt = cnt + CW'(push) - CW'(pop);
        if (clr_i)
        begin
            next_wp = '0;
            next_rp = '0;
            next_cnt = '0;
        end
    end
    // State registers.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end
    // Storage is written without reset.
    always_ff @(posedge clk_sys_i)
    begin
        if (push && !clr_i)
        begin
            mem[wp] <= in_data_i;
        end
    end
endmodule : line_fifo

// Notes on behaviour
// - Transmitter empty only when FIFO and shifter empty.
// - Holding empty sets on move, clears on load.
// - Holding empty plus enable raises transmit interrupt.
// - FIFO mode holding empty follows FIFO, except the lone-character delay.
// - Changing FIFO enable rearms transmit interrupt immediately.
// - Lone-character FIFO empty delayed nine bit times.
// - Break when input low beyond a word.
// - After break, wait half bit high first.
// - FIFO stores errors, shown when at head.
// - Zero stop bit flags a framing error.
// - Parity error per selected even or odd.
// - Status read clears four error flags.
// - Unread character replaced sets overrun.
// - Full FIFO: overrun at once, nothing pushed.
// - Data ready follows receive buffer or FIFO.
// - Error flags raise line status interrupt.
// - Status writes change all bits but seven.
// - Four priority levels, line status highest.
// - Identification frozen while being read.
// - Identification read-only, bits five, four zero.
// - Bits seven, six read 00 in character mode.
// - Reset value: source 000, pending-low 1.
// - Pending-low bit zero while interrupt pending.
// - FIFO timeout after four idle character times.
module uart_line_status_irq_id #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire uart_lsr_pkg::bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic baud16_tick_i,
    input wire logic serial_input_i,
    input wire logic parity_en_i,
    input wire logic parity_even_i,
    input wire logic modem_irq_i,
    output logic serial_output_o,
    output logic irq_o
);
    import uart_lsr_pkg::*;
    localparam int CW = $clog2(FIFO_DEPTH+1);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_LOW, RX_HIGH} rx_state_t;

    logic acc_q, acc_start, rd_go, wr_go, rd_lsr, rd_rbr, rd_ident, ident_acc;
    logic sin_meta, serial_input;
    rx_state_t rx_st, next_rx_st;
    logic [3:0] rx_tick, next_rx_tick, rx_bit, next_rx_bit, hi_cnt, next_hi_cnt;
    logic [7:0] rx_sh, next_rx_sh, low_cnt, next_low_cnt;
    logic par_bit, next_par_bit, rx_done, next_rx_done;
    rx_word_t rx_word, next_rx_word, rx_head;
    logic [7:0] word_ticks;
    logic rx_ready, rx_valid, rx_push, rx_pop, rx_clr, tx_clr;
    logic [CW-1:0] rx_cnt, tx_cnt;
    logic tx_ready, tx_valid, tx_push, tx_pop, tx_busy, next_tx_busy;
    logic [7:0] tx_head;
    logic [10:0] tx_frame, next_tx_frame;
    logic [3:0] tx_tick, next_tx_tick, tx_bits, next_tx_bits;
    logic [7:0] dly_cnt, next_dly_cnt;
    logic two_seen, next_two_seen, tx_holding_empty, tx_all_empty;
    logic fifo_mode, next_fifo_mode, tx_holding_empty_ack, next_tx_holding_empty_ack;
    logic [3:0] ier, next_ier;
    logic bi, fe, pe, oe, next_bi, next_fe, next_pe, next_oe;
    logic ovr_en, next_ovr_en, head_new, next_head_new;
    logic [2:0] ovr, next_ovr;
    logic [9:0] tmo_cnt, next_tmo_cnt;
    logic tmo, rls_irq, rda_irq, tx_holding_empty_irq, ms_irq, any_irq;
    logic [2:0] code;
    logic [7:0] lsr_val, ident_live, ident_hold, next_ident_hold, ident_out, next_rdata;

    // Bus access decode; side effects act on the first edge of an access.
    assign acc_start = bus_i.cs && (bus_i.rd || bus_i.wr) && !acc_q;
    assign rd_go = acc_start && bus_i.rd;
    assign wr_go = acc_start && bus_i.wr && !bus_i.rd;
    assign rd_lsr = rd_go && bus_i.addr == REG_LSTAT;
    assign rd_rbr = rd_go && bus_i.addr == REG_DATA;
    assign rd_ident = rd_go && bus_i.addr == REG_IDENT;
    assign ident_acc = bus_i.cs && bus_i.rd && bus_i.addr == REG_IDENT;

    // Receiver framing on the sixteen-times tick, reading the synchronised input.
    assign word_ticks = 8'((CHAR_BITS + 32'(parity_en_i)) * TICKS_PER_BIT);
    always_comb
    begin
        next_rx_st = rx_st;
        next_rx_tick = rx_tick;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_par_bit = par_bit;
        next_hi_cnt = hi_cnt;
        next_rx_done = 1'b0;
        next_rx_word = rx_word;
        next_low_cnt = serial_input ? 8'h00 : low_cnt;
        if (baud16_tick_i && !serial_input && low_cnt != 8'hFF)
        begin
            next_low_cnt = low_cnt + 8'h01;
        end
        if (baud16_tick_i)
        begin
            next_rx_tick = rx_tick + 4'h1;
            case (rx_st)
                RX_IDLE:
                begin
                    next_rx_tick = 4'h0;
                    if (!serial_input)
                    begin
                        next_rx_st = RX_START;
                    end
                end
                RX_START:
                    if (rx_tick == 4'(HALF_BIT_TICKS - 1))
                    begin
                        next_rx_st = serial_input ? RX_IDLE : RX_DATA;
                        next_rx_tick = 4'h0;
                        next_rx_bit = 4'h0;
                    end
                RX_DATA:
                    if (rx_tick == 4'(TICKS_PER_BIT - 1))
                    begin
                        next_rx_sh = {serial_input, rx_sh[7:1]};
                        next_rx_bit = rx_bit + 4'h1;
                        if (rx_bit == 4'h7)
                        begin
                            next_rx_st = parity_en_i ? RX_PAR : RX_STOP;
                        end
                    end
                RX_PAR:
                    if (rx_tick == 4'(TICKS_PER_BIT - 1))
                    begin
                        next_par_bit = serial_input;
                        next_rx_st = RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick == 4'(TICKS_PER_BIT - 1))
                    begin
                        next_rx_word.data = rx_sh;
                        next_rx_word.par = parity_en_i && ((^rx_sh ^ par_bit) == parity_even_i);
                        next_rx_word.brk = 1'b0;
                        next_rx_word.frm = !serial_input;
                        next_rx_done = serial_input;
                        next_rx_st = serial_input ? RX_IDLE : RX_LOW;
                    end
                RX_LOW:
                    if (serial_input)
                    begin
                        next_rx_done = 1'b1;
                        next_rx_st = RX_IDLE;
                    end
                    else if (low_cnt > word_ticks)
                    begin
                        next_rx_word = '{brk: 1'b1, frm: 1'b1, par: 1'b0, data: 8'h00};
                        next_rx_done = 1'b1;
                        next_hi_cnt = 4'h0;
                        next_rx_st = RX_HIGH;
                    end
                RX_HIGH:
                begin
                    next_hi_cnt = serial_input ? hi_cnt + 4'h1 : 4'h0;
                    if (serial_input && hi_cnt == 4'(HALF_BIT_TICKS - 1))
                    begin
                        next_rx_st = RX_IDLE;
                    end
                end
                default:
                    next_rx_st = RX_IDLE;
            endcase
        end
    end

    // Receive path into the FIFO; character mode keeps only the newest entry.
    assign rx_push = rx_done && rx_ready;
    assign rx_pop = rx_valid && (rd_rbr || (!fifo_mode && rx_done));
    line_fifo #(.W($bits(rx_word_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clr_i(rx_clr),
        .in_valid_i(rx_done),
        .in_ready_o(rx_ready),
        .in_data_i(rx_word),
        .out_valid_o(rx_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_head),
        .count_o(rx_cnt)
    );

    // Transmit FIFO drained by the shifter; writes to a full FIFO are dropped.
    assign tx_push = wr_go && bus_i.addr == REG_DATA && tx_ready;
    assign tx_pop = tx_valid && !tx_busy;
    line_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clr_i(tx_clr),
        .in_valid_i(tx_push),
        .in_ready_o(tx_ready),
        .in_data_i(bus_i.wdata),
        .out_valid_o(tx_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_head),
        .count_o(tx_cnt)
    );

    // Transmit shifter and the empty indications.
    assign tx_all_empty = !tx_valid && !tx_busy;
    assign tx_holding_empty = !tx_valid && (!fifo_mode || dly_cnt == 8'h00);
    always_comb
    begin
        next_tx_busy = tx_busy;
        next_tx_frame = tx_frame;
        next_tx_tick = tx_tick;
        next_tx_bits = tx_bits;
        next_dly_cnt = (baud16_tick_i && dly_cnt != 8'h00) ? dly_cnt - 8'h01 : dly_cnt;
        next_two_seen = (tx_cnt >= CW'(2)) || (two_seen && (tx_valid || dly_cnt != 8'h00));
        if (fifo_mode && tx_pop && tx_cnt == CW'(1) && !tx_push && !two_seen)
        begin
            next_dly_cnt = 8'(TX_EMPTY_DELAY_TICKS);
        end
        if (tx_pop)
        begin
            next_tx_frame = {1'b1, (^tx_head) ^ !parity_even_i, tx_head, 1'b0};
            if (!parity_en_i)
            begin
                next_tx_frame = {2'b11, tx_head, 1'b0};
            end
            next_tx_bits = parity_en_i ? 4'hB : 4'hA;
            next_tx_tick = 4'h0;
            next_tx_busy = 1'b1;
        end
        else if (tx_busy && baud16_tick_i)
        begin
            next_tx_tick = tx_tick + 4'h1;
            if (tx_tick == 4'(TICKS_PER_BIT - 1))
            begin
                next_tx_frame = {1'b1, tx_frame[10:1]};
                next_tx_bits = tx_bits - 4'h1;
                next_tx_busy = (tx_bits != 4'h1);
            end
        end
    end

    // Sticky errors; the set wins over a clear by the status read.
    always_comb
    begin
        next_bi = bi && !rd_lsr;
        next_fe = fe && !rd_lsr;
        next_pe = pe && !rd_lsr;
        next_oe = oe && !rd_lsr;
        next_head_new = (rx_push && !rx_valid) || (rx_pop && rx_cnt > CW'(1));
        if (rx_done && !fifo_mode)
        begin
            next_bi = next_bi || rx_word.brk;
            next_fe = next_fe || rx_word.frm;
            next_pe = next_pe || rx_word.par;
        end
        if (head_new && fifo_mode && rx_valid)
        begin
            next_bi = next_bi || rx_head.brk;
            next_fe = next_fe || rx_head.frm;
            next_pe = next_pe || rx_head.par;
        end
        if (rx_done && (fifo_mode ? !rx_ready : rx_valid))
        begin
            next_oe = 1'b1;
        end
        next_ovr_en = ovr_en && !(rx_push || rx_pop || tx_push || tx_pop);
        next_ovr = ovr;
        if (wr_go && bus_i.addr == REG_LSTAT)
        begin
            next_bi = bus_i.wdata[LS_BI];
            next_fe = bus_i.wdata[LS_FE];
            next_pe = bus_i.wdata[LS_PE];
            next_oe = bus_i.wdata[LS_OE];
            next_ovr = {bus_i.wdata[LS_TX_ALL_EMPTY], bus_i.wdata[LS_TX_HOLDING_EMPTY], bus_i.wdata[LS_DR]};
            next_ovr_en = 1'b1;
        end
    end

    // Control writes and the character timeout counter.
    assign rx_clr = wr_go && bus_i.addr == REG_IDENT && bus_i.wdata[FC_RX_CLR];
    assign tx_clr = wr_go && bus_i.addr == REG_IDENT && bus_i.wdata[FC_TX_CLR];
    always_comb
    begin
        next_ier = (wr_go && bus_i.addr == REG_IRQ_EN) ? bus_i.wdata[3:0] : ier;
        next_fifo_mode = (wr_go && bus_i.addr == REG_IDENT) ? bus_i.wdata[FC_ENABLE] : fifo_mode;
        next_tx_holding_empty_ack = (tx_holding_empty_ack && tx_holding_empty) || (rd_ident && ident_out[3:1] == ID_TX_HOLDING_EMPTY && tx_holding_empty_irq);
        if (next_fifo_mode != fifo_mode)
        begin
            next_tx_holding_empty_ack = 1'b0;
        end
        next_tmo_cnt = tmo_cnt;
        if (!rx_valid || rx_push || rx_pop)
        begin
            next_tmo_cnt = 10'h000;
        end
        else if (baud16_tick_i && tmo_cnt != 10'(TIMEOUT_TICKS))
        begin
            next_tmo_cnt = tmo_cnt + 10'h001;
        end
        next_ident_hold = rd_ident ? ident_live : ident_hold;
    end

    // Interrupt sources ranked into the identification value.
    assign tmo = fifo_mode && rx_valid && tmo_cnt == 10'(TIMEOUT_TICKS);
    assign rls_irq = ier[IE_RLS] && (bi || fe || pe || oe);
    assign rda_irq = ier[IE_RDA] && (rx_valid || tmo);
    assign tx_holding_empty_irq = ier[IE_TX_HOLDING_EMPTY] && tx_holding_empty && !tx_holding_empty_ack;
    assign ms_irq = ier[IE_MS] && modem_irq_i;
    assign any_irq = rls_irq || rda_irq || tx_holding_empty_irq || ms_irq;
    always_comb
    begin
        code = ID_MS;
        if (rls_irq)
            code = ID_RLS;
        else if (rda_irq)
            code = tmo ? ID_TMO : ID_RDA;
        else if (tx_holding_empty_irq)
            code = ID_TX_HOLDING_EMPTY;
    end
    assign ident_live = {fifo_mode ? MODE_FIFO : MODE_CHAR, 2'b00, code, !any_irq};
    assign ident_out = (ident_acc && !rd_ident) ? ident_hold : ident_live;
    assign irq_o = any_irq;

    // Read data; status overlays from a status write last until the next transfer.
    always_comb
    begin
        lsr_val = {fifo_mode && (bi || fe || pe), tx_all_empty, tx_holding_empty, bi, fe, pe, oe, rx_valid};
        if (ovr_en)
        begin
            lsr_val[LS_TX_ALL_EMPTY] = ovr[2];
            lsr_val[LS_TX_HOLDING_EMPTY] = ovr[1];
            lsr_val[LS_DR] = ovr[0];
        end
        case (bus_i.addr)
            REG_DATA: next_rdata = rx_head.data;
            REG_IRQ_EN: next_rdata = {4'h0, ier};
            REG_IDENT: next_rdata = ident_out;
            REG_LSTAT: next_rdata = lsr_val;
            default: next_rdata = 8'h00;
        endcase
        if (!(bus_i.cs && bus_i.rd))
        begin
            next_rdata = rdata_o;
        end
    end

    // Registers of every group.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_q <= 1'b0;
            sin_meta <= 1'b1;
            serial_input <= 1'b1;
            rx_st <= RX_IDLE;
            rx_tick <= 4'h0;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            par_bit <= 1'b0;
            hi_cnt <= 4'h0;
            low_cnt <= 8'h00;
            rx_done <= 1'b0;
            rx_word <= '0;
            tx_busy <= 1'b0;
            tx_frame <= 11'h7FF;
            tx_tick <= 4'h0;
            tx_bits <= 4'h0;
            dly_cnt <= 8'h00;
            two_seen <= 1'b0;
            {bi, fe, pe, oe} <= 4'h0;
            head_new <= 1'b0;
            ovr_en <= 1'b0;
            ovr <= 3'h0;
            ier <= IRQ_EN_RESET;
            fifo_mode <= 1'b0;
            tx_holding_empty_ack <= 1'b0;
            tmo_cnt <= 10'h000;
            ident_hold <= IDENT_RESET;
            rdata_o <= 8'h00;
        end
        else
        begin
            acc_q <= bus_i.cs && (bus_i.rd || bus_i.wr);
            sin_meta <= serial_input_i;
            serial_input <= sin_meta;
            rx_st <= next_rx_st;
            rx_tick <= next_rx_tick;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            par_bit <= next_par_bit;
            hi_cnt <= next_hi_cnt;
            low_cnt <= next_low_cnt;
            rx_done <= next_rx_done;
            rx_word <= next_rx_word;
            tx_busy <= next_tx_busy;
            tx_frame <= next_tx_frame;
            tx_tick <= next_tx_tick;
            tx_bits <= next_tx_bits;
            dly_cnt <= next_dly_cnt;
            two_seen <= next_two_seen;
            {bi, fe, pe, oe} <= {next_bi, next_fe, next_pe, next_oe};
            head_new <= next_head_new;
            ovr_en <= next_ovr_en;
            ovr <= next_ovr;
            ier <= next_ier;
            fifo_mode <= next_fifo_mode;
            tx_holding_empty_ack <= next_tx_holding_empty_ack;
            tmo_cnt <= next_tmo_cnt;
            ident_hold <= next_ident_hold;
            rdata_o <= next_rdata;
        end
    end
    assign serial_output_o = tx_frame[0];

    // Checks on the status and identification behaviour.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    AST_TX_ALL_EMPTY_BOTH_EMPTY: assert property (lsr_val[LS_TX_ALL_EMPTY] && !ovr_en |-> !tx_valid && !tx_busy)
        else $error("transmitter empty shown while data remains");
    AST_TX_HOLDING_EMPTY_LOAD: assert property (tx_push && !fifo_mode |=> !tx_holding_empty)
        else $error("holding empty not cleared by load");
    AST_TX_HOLDING_EMPTY_IRQ: assert property (ier[IE_TX_HOLDING_EMPTY] && tx_holding_empty && !tx_holding_empty_ack |-> any_irq)
        else $error("transmit interrupt missing");
    AST_LSR_CLEAR: assert property (rd_lsr && !rx_done && !head_new && !next_oe |=> !(bi || fe || pe || oe))
        else $error("status read did not clear errors");
    AST_OVERRUN_FULL: assert property (fifo_mode && rx_done && !rx_ready |=> oe && $stable(rx_cnt) || $past(rx_pop))
        else $error("overrun on full FIFO not flagged");
    AST_DELAY_LEN: assert property ($rose(dly_cnt != 8'h00) |-> dly_cnt == 8'(TX_EMPTY_DELAY_TICKS))
        else $error("empty delay length wrong");
    AST_IDENT_FROZEN: assert property (ident_acc && $past(ident_acc) && !rd_ident |-> $stable(ident_out))
        else $error("identification changed during access");
    AST_RLS_FIRST: assert property (rls_irq |-> ident_live[3:0] == {ID_RLS, 1'b0})
        else $error("line status not highest priority");
    AST_PENDING_LOW: assert property (ident_live[0] == !any_irq && ident_live[5:4] == 2'b00)
        else $error("pending bit wrong");
    AST_BREAK_HOLD: assert property (rx_st == RX_HIGH && next_rx_st == RX_IDLE |-> serial_input ##0 $past(serial_input))
        else $error("receiver restarted without high time");
    COV_OVERRUN: cover property (rx_done && fifo_mode && !rx_ready);
    COV_BREAK: cover property (rx_done && rx_word.brk);
    COV_TIMEOUT: cover property (rda_irq && tmo);
endmodule : uart_line_status_irq_id

//--- test/host_cpu_model.sv
`timescale 1ns/10ps
// Host processor that makes single register cycles on the parallel bus.
module host_cpu_model (
    input wire logic clk_sys_i,
    output uart_lsr_pkg::bus_req_t bus_o
);
    import uart_lsr_pkg::*;
    // Holds one cycle through the given number of sampling edges, then releases with scrambled address and data.
    // A read held past its first edge makes the read data reload, so plain reads hold for one edge only.
    task automatic access(input logic wr, input logic [2:0] addr, input logic [7:0] wdata, input int edges);
        bus_o = '{cs: 1'b1, rd: !wr, wr: wr, addr: addr, wdata: wdata};
        repeat (edges) @(negedge clk_sys_i);
        bus_o = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        @(negedge clk_sys_i);
    endtask : access
    // The bus is idle from time zero.
    initial
    begin
        bus_o = '0;
    end
endmodule : host_cpu_model

//--- test/tb.sv
`timescale 1ns/10ps
// Self-checking bench for line status and interrupt identification.
module tb;
    import uart_lsr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic tick = 1'b0;
    logic serial_in = 1'b1;
    logic loop = 1'b0;
    logic par_en = 1'b0;
    logic par_even = 1'b0;
    logic txd;
    bus_req_t bus;
    logic [7:0] rdata;
    logic irq;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    // Clock, a baud tick every other cycle, and the hang limit.
    always #4 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i)
    begin
        tick <= ~tick;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            end_sim();
        end
    end
    host_cpu_model i_host_cpu_model (.clk_sys_i(clk_sys_i), .bus_o(bus));
    uart_line_status_irq_id #(.FIFO_DEPTH(32)) i_uart_line_status_irq_id (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .bus_i(bus), .rdata_o(rdata), .baud16_tick_i(tick), .serial_input_i(loop ? txd : serial_in),
        .parity_en_i(par_en), .parity_even_i(par_even), .modem_irq_i(1'b0), .serial_output_o(txd), .irq_o(irq));
    // Compares one byte and reports a mismatch.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp)
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            fails = fails + 1;
    endtask : check
    // Reads one register and compares it.
    task automatic rd(input logic [2:0] addr, input logic [7:0] exp);
        i_host_cpu_model.access(1'b0, addr, 8'h00, 1);
        check(rdata, exp);
    endtask : rd
    // Sends one character lowest bit first, 32 cycles a bit, with the given stop level.
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            serial_in = f[i];
            repeat (32) @(negedge clk_sys_i);
        end
        serial_in = 1'b1;
        repeat (64) @(negedge clk_sys_i);
    endtask : send
    // Values straight after reset.
    task automatic t_reset;
        rd(REG_IDENT, 8'h01);
        rd(REG_LSTAT, 8'h60);
    endtask : t_reset
    // A bad stop bit outranks waiting data and is cleared by a status read.
    task automatic t_frame;
        i_host_cpu_model.access(1'b1, REG_IRQ_EN, 8'h07, 1);
        send(8'hFF, 1'b0);
        check({7'h00, irq}, 8'h01);
        rd(REG_IDENT, 8'h06);
        rd(REG_LSTAT, 8'h69);
        rd(REG_IDENT, 8'h04);
        rd(REG_DATA, 8'hFF);
        rd(REG_LSTAT, 8'h60);
    endtask : t_frame
    // An unread character is replaced and the transmit source follows.
    task automatic t_overrun;
        send(8'hA5, 1'b1);
        send(8'h5A, 1'b1);
        rd(REG_LSTAT, 8'h63);
        rd(REG_DATA, 8'h5A);
        rd(REG_IDENT, 8'h02);
    endtask : t_overrun
    // Looped-back character; the parity sense flips after the load so the receiver sees a parity error.
    task automatic t_tx;
        loop = 1'b1;
        par_en = 1'b1;
        par_even = 1'b1;
        i_host_cpu_model.access(1'b1, REG_DATA, 8'h55, 1);
        par_even = 1'b0;
        rd(REG_LSTAT, 8'h20);
        repeat (380) @(negedge clk_sys_i);
        rd(REG_LSTAT, 8'h65);
        rd(REG_DATA, 8'h55);
        loop = 1'b0;
        par_en = 1'b0;
    endtask : t_tx
    // FIFO mode shows in the top bits, rearms the transmit source and holds a long identification read.
    task automatic t_fifo;
        i_host_cpu_model.access(1'b1, REG_IDENT, 8'h01, 1);
        i_host_cpu_model.access(1'b0, REG_IDENT, 8'h00, 3);
        check(rdata, 8'hC2);
        rd(REG_IDENT, 8'hC1);
        i_host_cpu_model.access(1'b1, REG_DATA, 8'h3C, 1);
        rd(REG_LSTAT, 8'h00);
        repeat (400) @(negedge clk_sys_i);
        rd(REG_LSTAT, 8'h60);
    endtask : t_fifo
    // Writes reach every status bit but the top one, which reports errors in FIFO mode.
    task automatic t_write;
        i_host_cpu_model.access(1'b1, REG_LSTAT, 8'h9E, 1);
        rd(REG_LSTAT, 8'h9E);
        i_host_cpu_model.access(1'b1, REG_LSTAT, 8'h80, 1);
        rd(REG_LSTAT, 8'h00);
    endtask : t_write
    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Main sequence.
    initial
    begin
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        t_reset();
        t_frame();
        t_overrun();
        t_tx();
        t_fifo();
        t_write();
        end_sim();
    end
endmodule : tb
